// ==== include/sfr_bank1_pkg.sv ====
// Package for the second special function register bank of the core.
// Assumes byte-wide registers and an 8-bit register address from the core.
package sfr_bank1_pkg;

  // Register addresses in the second bank.
  localparam logic [7:0] ADDR_INDIRECT = 8'h80;
  localparam logic [7:0] ADDR_OPTION = 8'h81;
  localparam logic [7:0] ADDR_PC_LOW = 8'h82;
  localparam logic [7:0] ADDR_STATUS = 8'h83;
  localparam logic [7:0] ADDR_POINTER = 8'h84;
  localparam logic [7:0] ADDR_DIR_A = 8'h85;
  localparam logic [7:0] ADDR_DIR_B = 8'h86;
  localparam logic [7:0] ADDR_DIR_C = 8'h87;
  localparam logic [7:0] ADDR_DIR_D = 8'h88;
  localparam logic [7:0] ADDR_DIR_E = 8'h89;
  localparam logic [7:0] ADDR_PC_LATCH = 8'h8a;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h8b;
  localparam logic [7:0] ADDR_PERIPH_EN = 8'h8c;
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'h8e;
  localparam logic [7:0] ADDR_T2_PERIOD = 8'h92;
  localparam logic [7:0] ADDR_SER_ADDR = 8'h93;
  localparam logic [7:0] ADDR_SER_STATUS = 8'h94;
  // Bank select bit of the address; cleared it gives the mirror address.
  localparam int BANK_BIT = 7;

  // Implemented bit masks.
  localparam logic [7:0] MASK_DIR_A = 8'h3f;
  localparam logic [7:0] MASK_DIR_E = 8'h17;
  localparam logic [7:0] MASK_PC_LATCH = 8'h1f;
  localparam logic [7:0] MASK_PERIPH_EN = 8'hcf;
  localparam logic [7:0] MASK_RESET_CAUSE = 8'h03;
  localparam logic [7:0] MASK_SER_STATUS = 8'h3f;

  // Reset values.
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_PC_LOW = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_DIR_A = 8'h3f;
  localparam logic [7:0] RST_DIR_BCD = 8'hff;
  localparam logic [7:0] RST_DIR_E = 8'h07;
  localparam logic [7:0] RST_PC_LATCH = 8'h00;
  localparam logic [7:0] RST_INT_CTRL = 8'h00;
  localparam logic [7:0] RST_PERIPH_EN = 8'h00;
  localparam logic [7:0] RST_T2_PERIOD = 8'hff;
  localparam logic [7:0] RST_SER_ADDR = 8'h00;
  localparam logic [7:0] RST_SER_STATUS = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Field positions.
  localparam int ST_TIMEOUT = 4;
  localparam int ST_POWERDOWN = 3;
  localparam int DIR_E_PSP_MODE = 4;
  localparam int DIR_E_OVERFLOW = 5;
  localparam int CAUSE_POWER_ON = 1;
  localparam int CAUSE_BROWNOUT = 0;
  localparam int INT_EDGE_FLAG = 0;
  localparam int PC_WIDTH = 13;
  localparam int PC_LOW_WIDTH = 8;
  localparam int TARGET_WIDTH = 11;

  // Register selected by a core address.
  typedef enum logic [4:0] {
    SEL_NONE, SEL_INDIRECT, SEL_OPTION, SEL_PC_LOW, SEL_STATUS,
    SEL_POINTER, SEL_DIR_A, SEL_DIR_B, SEL_DIR_C, SEL_DIR_D, SEL_DIR_E,
    SEL_PC_LATCH, SEL_INT_CTRL, SEL_PERIPH_EN, SEL_RESET_CAUSE,
    SEL_T2_PERIOD, SEL_SER_ADDR, SEL_SER_STATUS
  } reg_sel_t;

  // Configuration handed to the peripherals.
  typedef struct packed {
    logic [7:0] option;
    logic [7:0] status;
    logic [7:0] int_ctrl;
    logic [7:0] periph_en;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
    logic [7:0] dir_d;
    logic [7:0] dir_e;
    logic [7:0] t2_period;
    logic [7:0] ser_addr;
  } sfr_config_t;

  // Parallel slave port status from the port logic.
  typedef struct packed {
    logic in_full;
    logic out_full;
    logic overflow_evt;
  } psp_status_t;

endpackage

// ==== verilog/data_ram.sv ====
// General purpose data memory reached through the indirect access port.
// Assumes writes are single-cycle strobes on the core clock.
`timescale 1ns/10ps
module data_ram
  import sfr_bank1_pkg::*;
#(
  parameter int ADDR_W = 7
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] index,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  // Refuse sizes the 8-bit pointer cannot reach.
  initial begin
    if (ADDR_W < 1 || ADDR_W > 8) begin
      $error("data_ram: ADDR_W must be 1 to 8");
    end
  end

  logic [7:0] mem_ff [2**ADDR_W];

  // Stores a byte on a write strobe; contents are unknown after power-up.
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_ff[index] <= wdata;
    end
  end

  // Reads the addressed byte without delay.
  assign rdata = mem_ff[index];

endmodule

// ==== verilog/sfr_bank1.sv ====
// Second bank of the special function register file with its mirrors.
// Assumes all inputs are synchronous to ref_clk and the core issues at most
// one register strobe per cycle; rst is the power-on reset.
`timescale 1ns/10ps

// How it works
// - Unmapped addresses and unimplemented bits read back as zero.
// - Pointer, port, counter low, status, latch, interrupt regs mirror in banks.
// - Upper program counter has no address; only the latch reaches it.
// - The latch supplies counter bits twelve to eight on low-byte writes, twelve and eleven on jumps.
// - Pin or watchdog reset applies the other column, keeping unchanged fields.
// - Unknown bits start at zero, unchanged keep value, conditional follow cause.
module sfr_bank1
  import sfr_bank1_pkg::*;
#(
  parameter int RAM_ADDR_W = 7
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic brownout_rst,
  input wire logic external_reset_pin,
  input wire logic watchdog_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic core_pc_inc,
  input wire logic core_pc_load,
  input wire logic [TARGET_WIDTH-1:0] core_pc_target,
  input wire psp_status_t psp_status,
  input wire logic [5:0] serial_status,
  output sfr_config_t sfr_config,
  output logic [PC_WIDTH-1:0] pc_value
);

  // Refuse memory sizes the pointer cannot index.
  initial begin
    if (RAM_ADDR_W < 1 || RAM_ADDR_W > 8) begin
      $error("sfr_bank1: RAM_ADDR_W must be 1 to 8");
    end
  end

  // Maps a core address onto a register; mirrored ones ignore the bank bit.
  function automatic reg_sel_t decode(input logic [7:0] addr);
    logic [7:0] hi;
    hi = addr | (8'h01 << BANK_BIT);
    decode = SEL_NONE;
    if (hi == ADDR_INDIRECT) begin
      decode = SEL_INDIRECT;
    end else if (hi == ADDR_PC_LOW) begin
      decode = SEL_PC_LOW;
    end else if (hi == ADDR_STATUS) begin
      decode = SEL_STATUS;
    end else if (hi == ADDR_POINTER) begin
      decode = SEL_POINTER;
    end else if (hi == ADDR_PC_LATCH) begin
      decode = SEL_PC_LATCH;
    end else if (hi == ADDR_INT_CTRL) begin
      decode = SEL_INT_CTRL;
    end else if (addr == ADDR_OPTION) begin
      decode = SEL_OPTION;
    end else if (addr == ADDR_DIR_A) begin
      decode = SEL_DIR_A;
    end else if (addr == ADDR_DIR_B) begin
      decode = SEL_DIR_B;
    end else if (addr == ADDR_DIR_C) begin
      decode = SEL_DIR_C;
    end else if (addr == ADDR_DIR_D) begin
      decode = SEL_DIR_D;
    end else if (addr == ADDR_DIR_E) begin
      decode = SEL_DIR_E;
    end else if (addr == ADDR_PERIPH_EN) begin
      decode = SEL_PERIPH_EN;
    end else if (addr == ADDR_RESET_CAUSE) begin
      decode = SEL_RESET_CAUSE;
    end else if (addr == ADDR_T2_PERIOD) begin
      decode = SEL_T2_PERIOD;
    end else if (addr == ADDR_SER_ADDR) begin
      decode = SEL_SER_ADDR;
    end else if (addr == ADDR_SER_STATUS) begin
      decode = SEL_SER_STATUS;
    end
  endfunction

  logic [7:0] option_ff;
  logic [7:0] status_ff;
  logic [7:0] pointer_ff;
  logic [7:0] dir_a_ff;
  logic [7:0] dir_b_ff;
  logic [7:0] dir_c_ff;
  logic [7:0] dir_d_ff;
  logic [7:0] dir_e_ff;
  logic [7:0] pc_latch_ff;
  logic [7:0] int_ctrl_ff;
  logic [7:0] periph_en_ff;
  logic [7:0] cause_ff;
  logic [7:0] t2_period_ff;
  logic [7:0] ser_addr_ff;
  logic [7:0] ser_status_ff;
  logic [PC_WIDTH-1:0] pc_ff;
  logic [7:0] reg_rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] ram_rdata;
  logic ram_wr;
  logic pointer_self;
  logic full_rst;
  logic other_rst;
  reg_sel_t wr_sel;

  // Brown-out takes the power-up column; pin and watchdog the other one.
  assign full_rst = brownout_rst;
  assign other_rst = external_reset_pin | watchdog_rst;
  assign wr_sel = decode(reg_addr);

  // Indirect redirect; a pointer at the port itself reaches nothing.
  assign pointer_self = decode(pointer_ff) == SEL_INDIRECT;
  assign ram_wr = reg_wr && wr_sel == SEL_INDIRECT && !pointer_self
    && !full_rst && !other_rst;

  data_ram #(
    .ADDR_W(RAM_ADDR_W)
  ) u_data_ram (
    .ref_clk(ref_clk),
    .wr_en(ram_wr),
    .index(pointer_ff[RAM_ADDR_W-1:0]),
    .wdata(reg_wdata),
    .rdata(ram_rdata)
  );

  // Option register: all ones after every reset.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      option_ff <= RST_OPTION;
    end else if (full_rst || other_rst) begin
      option_ff <= RST_OPTION;
    end else if (reg_wr && wr_sel == SEL_OPTION) begin
      option_ff <= reg_wdata;
    end
  end

  // Status register: bank selects clear, flags unknown start at zero.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_ff <= RST_STATUS;
    end else if (full_rst) begin
      status_ff <= {RST_STATUS[7:3], status_ff[2:0]};
    end else if (other_rst) begin
      status_ff[7:5] <= 3'h0;
      if (watchdog_rst) begin
        status_ff[ST_TIMEOUT] <= 1'b0;
      end
    end else if (reg_wr && wr_sel == SEL_STATUS) begin
      // Time-out and power-down flags are not writable by software.
      status_ff[7:5] <= reg_wdata[7:5];
      status_ff[2:0] <= reg_wdata[2:0];
    end
  end

  // Indirect pointer: unknown at power-up, kept over other resets.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pointer_ff <= 8'h00;
    end else if (reg_wr && wr_sel == SEL_POINTER && !full_rst
                 && !other_rst) begin
      pointer_ff <= reg_wdata;
    end
  end

  // Port direction registers: inputs after every reset.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dir_a_ff <= RST_DIR_A;
      dir_b_ff <= RST_DIR_BCD;
      dir_c_ff <= RST_DIR_BCD;
      dir_d_ff <= RST_DIR_BCD;
    end else if (full_rst || other_rst) begin
      dir_a_ff <= RST_DIR_A;
      dir_b_ff <= RST_DIR_BCD;
      dir_c_ff <= RST_DIR_BCD;
      dir_d_ff <= RST_DIR_BCD;
    end else if (reg_wr) begin
      if (wr_sel == SEL_DIR_A) begin
        dir_a_ff <= reg_wdata & MASK_DIR_A;
      end
      if (wr_sel == SEL_DIR_B) begin
        dir_b_ff <= reg_wdata;
      end
      if (wr_sel == SEL_DIR_C) begin
        dir_c_ff <= reg_wdata;
      end
      if (wr_sel == SEL_DIR_D) begin
        dir_d_ff <= reg_wdata;
      end
    end
  end

  // Port E direction with parallel port status; overflow is sticky.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dir_e_ff <= RST_DIR_E;
    end else if (full_rst || other_rst) begin
      dir_e_ff <= RST_DIR_E;
    end else begin
      if (reg_wr && wr_sel == SEL_DIR_E) begin
        dir_e_ff <= reg_wdata & MASK_DIR_E;
      end
      // An overflow arriving with a clearing write still sets the flag.
      if (psp_status.overflow_evt) begin
        dir_e_ff[DIR_E_OVERFLOW] <= 1'b1;
      end else if (reg_wr && wr_sel == SEL_DIR_E) begin
        dir_e_ff[DIR_E_OVERFLOW] <= reg_wdata[DIR_E_OVERFLOW];
      end
    end
  end

  // Counter high latch: the only way to the upper counter bits.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc_latch_ff <= RST_PC_LATCH;
    end else if (full_rst || other_rst) begin
      pc_latch_ff <= RST_PC_LATCH;
    end else if (reg_wr && wr_sel == SEL_PC_LATCH) begin
      pc_latch_ff <= reg_wdata & MASK_PC_LATCH;
    end
  end

  // Program counter: reset to zero, written low byte, jumps or increments.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pc_ff <= '0;
    end else if (full_rst || other_rst) begin
      pc_ff <= '0;
    end else if (reg_wr && wr_sel == SEL_PC_LOW) begin
      // Latch fills bits twelve to eight.
      pc_ff <= {pc_latch_ff[PC_WIDTH-PC_LOW_WIDTH-1:0], reg_wdata};
    end else if (core_pc_load) begin
      // Latch fills bits above the target.
      pc_ff <= {pc_latch_ff[PC_WIDTH-PC_LOW_WIDTH-1:TARGET_WIDTH-PC_LOW_WIDTH],
                core_pc_target};
    end else if (core_pc_inc) begin
      pc_ff <= pc_ff + 13'h0001;
    end
  end

  // Interrupt control: cleared, except the change flag kept on other resets.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      int_ctrl_ff <= RST_INT_CTRL;
    end else if (full_rst) begin
      int_ctrl_ff <= RST_INT_CTRL;
    end else if (other_rst) begin
      int_ctrl_ff <= {7'h00, int_ctrl_ff[INT_EDGE_FLAG]};
    end else if (reg_wr && wr_sel == SEL_INT_CTRL) begin
      int_ctrl_ff <= reg_wdata;
    end
  end

  // Peripheral interrupt enables, timer period and serial address.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      periph_en_ff <= RST_PERIPH_EN;
      t2_period_ff <= RST_T2_PERIOD;
      ser_addr_ff <= RST_SER_ADDR;
    end else if (full_rst || other_rst) begin
      periph_en_ff <= RST_PERIPH_EN;
      t2_period_ff <= RST_T2_PERIOD;
      ser_addr_ff <= RST_SER_ADDR;
    end else if (reg_wr) begin
      // Bit six is stored as written; software keeps it zero.
      if (wr_sel == SEL_PERIPH_EN) begin
        periph_en_ff <= reg_wdata & MASK_PERIPH_EN;
      end
      if (wr_sel == SEL_T2_PERIOD) begin
        t2_period_ff <= reg_wdata;
      end
      if (wr_sel == SEL_SER_ADDR) begin
        ser_addr_ff <= reg_wdata;
      end
    end
  end

  // Reset cause flags: power-on clears both flags, brown-out clears its own flag.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cause_ff <= 8'h00;
    end else if (full_rst) begin
      cause_ff[CAUSE_BROWNOUT] <= 1'b0;
    end else if (other_rst) begin
      cause_ff <= cause_ff;
    end else if (reg_wr && wr_sel == SEL_RESET_CAUSE) begin
      cause_ff <= reg_wdata & MASK_RESET_CAUSE;
    end
  end

  // Serial port status mirrors the port's own flags.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ser_status_ff <= RST_SER_STATUS;
    end else if (full_rst || other_rst) begin
      ser_status_ff <= RST_SER_STATUS;
    end else begin
      ser_status_ff <= {2'h0, serial_status} & MASK_SER_STATUS;
    end
  end

  // Read multiplexer; parallel port full flags come straight from the port.
  always_comb begin
    nxt_rdata = READ_ZERO;
    case (wr_sel)
      SEL_INDIRECT: nxt_rdata = pointer_self ? READ_ZERO : ram_rdata;
      SEL_OPTION: nxt_rdata = option_ff;
      SEL_PC_LOW: nxt_rdata = pc_ff[PC_LOW_WIDTH-1:0];
      SEL_STATUS: nxt_rdata = status_ff;
      SEL_POINTER: nxt_rdata = pointer_ff;
      SEL_DIR_A: nxt_rdata = dir_a_ff;
      SEL_DIR_B: nxt_rdata = dir_b_ff;
      SEL_DIR_C: nxt_rdata = dir_c_ff;
      SEL_DIR_D: nxt_rdata = dir_d_ff;
      SEL_DIR_E: nxt_rdata = {psp_status.in_full, psp_status.out_full,
                              dir_e_ff[5:0]};
      SEL_PC_LATCH: nxt_rdata = pc_latch_ff;
      SEL_INT_CTRL: nxt_rdata = int_ctrl_ff;
      SEL_PERIPH_EN: nxt_rdata = periph_en_ff;
      SEL_RESET_CAUSE: nxt_rdata = cause_ff;
      SEL_T2_PERIOD: nxt_rdata = t2_period_ff;
      SEL_SER_ADDR: nxt_rdata = ser_addr_ff;
      SEL_SER_STATUS: nxt_rdata = ser_status_ff;
      default: nxt_rdata = READ_ZERO;
    endcase
  end

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= READ_ZERO;
    end
  end

  // Outputs, all straight from registers.
  assign reg_rdata = reg_rdata_ff;
  assign pc_value = pc_ff;
  assign sfr_config = '{option: option_ff, status: status_ff,
    int_ctrl: int_ctrl_ff, periph_en: periph_en_ff, dir_a: dir_a_ff,
    dir_b: dir_b_ff, dir_c: dir_c_ff, dir_d: dir_d_ff, dir_e: dir_e_ff,
    t2_period: t2_period_ff, ser_addr: ser_addr_ff};

endmodule

// ==== bench/sfr_bank1_sva.sv ====
// Port checker for the second register bank.
// Assumes one clock domain; rst is the asynchronous power-on reset.
`timescale 1ns/10ps
module sfr_bank1_sva
  import sfr_bank1_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic brownout_rst,
  input wire logic external_reset_pin,
  input wire logic watchdog_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic core_pc_inc,
  input wire logic core_pc_load,
  input wire logic [TARGET_WIDTH-1:0] core_pc_target,
  input wire sfr_config_t sfr_config,
  input wire logic [PC_WIDTH-1:0] pc_value
);
  logic srst;
  logic [4:0] latch_ff;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Any synchronous reset cause blocks writes.
  assign srst = brownout_rst | external_reset_pin | watchdog_rst;
  // Shadow of the counter high latch, rebuilt from bus writes.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latch_ff <= 5'h00;
    end else if (srst) begin
      latch_ff <= 5'h00;
    end else if (reg_wr && reg_addr[6:0] == 7'h0a) begin
      latch_ff <= reg_wdata[4:0];
    end
  end
  property p_hole;
    reg_rd && reg_addr inside {8'h8d, 8'h8f, 8'h90, 8'h91, [8'h95:8'h9f]}
    |=> reg_rdata == 8'h00;
  endproperty
  a_hole: assert property (p_hole) else $error("hole not zero");
  property p_stat;
    reg_rd && reg_addr[6:0] == 7'h03 |=> reg_rdata == $past(sfr_config.status);
  endproperty
  a_stat: assert property (p_stat) else $error("status read bad");
  property p_pcrd;
    reg_rd && reg_addr[6:0] == 7'h02 |=> reg_rdata == $past(pc_value[7:0]);
  endproperty
  a_pcrd: assert property (p_pcrd) else $error("pc low read bad");
  property p_pcwr;
    reg_wr && reg_addr[6:0] == 7'h02 && !srst
    |=> pc_value == {$past(latch_ff), $past(reg_wdata)};
  endproperty
  a_pcwr: assert property (p_pcwr) else $error("pc write bad");
  property p_load;
    core_pc_load && !reg_wr && !srst
    |=> pc_value == {$past(latch_ff[4:3]), $past(core_pc_target)};
  endproperty
  a_load: assert property (p_load) else $error("pc load bad");
  property p_inc;
    core_pc_inc && !core_pc_load && !reg_wr && !srst
    |=> pc_value == $past(pc_value) + 13'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("pc step bad");
  property p_pin;
    external_reset_pin |=> pc_value == 13'h0000 && sfr_config.option == 8'hff
      && sfr_config.status[7:5] == 3'h0 && sfr_config.int_ctrl[7:1] == 7'h00;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset bad");
  property p_wdog;
    watchdog_rst |=> !sfr_config.status[4] && sfr_config.dir_a == 8'h3f
      && sfr_config.int_ctrl[0] == $past(sfr_config.int_ctrl[0]);
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset bad");
endmodule

bind sfr_bank1 sfr_bank1_sva u_sva (.ref_clk(ref_clk), .rst(rst),
  .brownout_rst(brownout_rst), .external_reset_pin(external_reset_pin),
  .watchdog_rst(watchdog_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .core_pc_inc(core_pc_inc), .core_pc_load(core_pc_load),
  .core_pc_target(core_pc_target), .sfr_config(sfr_config),
  .pc_value(pc_value));

// ==== bench/testbench.sv ====
// Self-checking bench for the second register bank.
// Assumes the package and design are compiled first; no partner model.
`timescale 1ns/10ps
module testbench
  import sfr_bank1_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst, brownout_rst, external_reset_pin, watchdog_rst;
  logic reg_wr, reg_rd, core_pc_inc, core_pc_load;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [TARGET_WIDTH-1:0] core_pc_target;
  logic [5:0] serial_status;
  logic [PC_WIDTH-1:0] pc_value;
  psp_status_t psp_status;
  sfr_config_t sfr_config;
  int n_fail = 0;
  int compares = 0;
  localparam logic [15:0] RST_TAB [15] = '{16'h81ff, 16'h8200, 16'h8318,
    16'h853f, 16'h86ff, 16'h87ff, 16'h88ff, 16'h8907, 16'h8a00, 16'h8b00,
    16'h8c00, 16'h8e00, 16'h92ff, 16'h9300, 16'h9400};
  localparam logic [7:0] HOLES [8] = '{8'h8d, 8'h8f, 8'h90, 8'h91, 8'h95,
    8'h9f, 8'h01, 8'h3f};

  sfr_bank1 #(.RAM_ADDR_W(7)) u_sfr_bank1 (
    .ref_clk(ref_clk),
    .rst(rst),
    .brownout_rst(brownout_rst),
    .external_reset_pin(external_reset_pin),
    .watchdog_rst(watchdog_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .core_pc_inc(core_pc_inc),
    .core_pc_load(core_pc_load),
    .core_pc_target(core_pc_target),
    .psp_status(psp_status),
    .serial_status(serial_status),
    .sfr_config(sfr_config),
    .pc_value(pc_value)
  );

  // Free-running 20 MHz core clock.
  always #25 ref_clk = ~ref_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk({8'h00, d}, {8'h00, e});
  endtask

  task automatic sr(input logic [2:0] m);
    @(posedge ref_clk);
    {brownout_rst, external_reset_pin, watchdog_rst} <= m;
    @(posedge ref_clk);
    {brownout_rst, external_reset_pin, watchdog_rst} <= 3'b000;
  endtask

  task automatic t_reset;
    for (int i = 0; i < 15; i++) begin
      rc(RST_TAB[i][15:8], RST_TAB[i][7:0]);
    end
  endtask

  task automatic t_holes;
    for (int i = 0; i < 8; i++) begin
      rc(HOLES[i], 8'h00);
    end
    wr(8'h8d, 8'hff);
    rc(8'h8d, 8'h00);
    wr(8'h85, 8'hff);
    rc(8'h85, 8'h3f);
    chk({8'h00, sfr_config.dir_a}, 16'h003f);
    wr(8'h8a, 8'hff);
    rc(8'h8a, 8'h1f);
    wr(8'h8e, 8'hff);
    rc(8'h8e, 8'h03);
    wr(8'h8c, 8'hbf);
    rc(8'h8c, 8'h8f);
    @(posedge ref_clk);
    serial_status <= 6'h3f;
    wr(8'h94, 8'h00);
    rc(8'h94, 8'h3f);
  endtask

  task automatic t_mirror;
    wr(8'h0a, 8'h12);
    rc(8'h8a, 8'h12);
    wr(8'h84, 8'h55);
    rc(8'h04, 8'h55);
    wr(8'h8b, 8'h5a);
    rc(8'h0b, 8'h5a);
    wr(8'h03, 8'h07);
    rc(8'h83, 8'h1f);
    wr(8'h83, 8'h00);
    rc(8'h03, 8'h18);
  endtask

  task automatic t_pc;
    wr(8'h8a, 8'h15);
    wr(8'h82, 8'h34);
    #1;
    chk({3'h0, pc_value}, 16'h1534);
    rc(8'h02, 8'h34);
    wr(8'h0a, 8'h1f);
    @(posedge ref_clk);
    core_pc_load <= 1'b1;
    core_pc_target <= 11'h123;
    @(posedge ref_clk);
    core_pc_load <= 1'b0;
    #1;
    chk({3'h0, pc_value}, 16'h1923);
    wr(8'h8a, 8'h00);
    wr(8'h82, 8'hff);
    @(posedge ref_clk);
    core_pc_inc <= 1'b1;
    @(posedge ref_clk);
    core_pc_inc <= 1'b0;
    #1;
    chk({3'h0, pc_value}, 16'h0100);
  endtask

  task automatic t_ind;
    wr(8'h84, 8'h20);
    wr(8'h80, 8'ha5);
    wr(8'h84, 8'h21);
    wr(8'h00, 8'h3c);
    wr(8'h84, 8'h20);
    rc(8'h00, 8'ha5);
    wr(8'h84, 8'h21);
    rc(8'h80, 8'h3c);
    wr(8'h84, 8'h80);
    rc(8'h80, 8'h00);
  endtask

  task automatic t_dir_e;
    @(posedge ref_clk);
    psp_status <= '{1'b1, 1'b0, 1'b1};
    @(posedge ref_clk);
    psp_status <= '{1'b1, 1'b0, 1'b0};
    rc(8'h89, 8'ha7);
    wr(8'h89, 8'h00);
    rc(8'h89, 8'h80);
    wr(8'h89, 8'hff);
    rc(8'h89, 8'hb7);
  endtask

  task automatic t_sync;
    wr(8'h81, 8'h12);
    wr(8'h8b, 8'hff);
    wr(8'h84, 8'h77);
    @(posedge ref_clk);
    external_reset_pin <= 1'b1;
    reg_wr <= 1'b1;
    reg_addr <= 8'h86;
    reg_wdata <= 8'h00;
    @(posedge ref_clk);
    external_reset_pin <= 1'b0;
    reg_wr <= 1'b0;
    #1;
    chk({3'h0, pc_value}, 16'h0000);
    rc(8'h86, 8'hff);
    rc(8'h81, 8'hff);
    rc(8'h8b, 8'h01);
    rc(8'h84, 8'h77);
    sr(3'b001);
    rd(8'h83);
    chk({12'h000, d[7:4]}, 16'h0000);
    wr(8'h8e, 8'h03);
    sr(3'b100);
    rc(8'h8e, 8'h02);
    rc(8'h84, 8'h77);
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence: reset for three cycles, then every scenario in turn.
  initial begin
    rst = 1'b1;
    {brownout_rst, external_reset_pin, watchdog_rst} = 3'b000;
    {reg_wr, reg_rd, core_pc_inc, core_pc_load} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    core_pc_target = 11'h000;
    psp_status = '{1'b0, 1'b0, 1'b0};
    serial_status = 6'h00;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_holes();
    t_mirror();
    t_pc();
    t_ind();
    t_dir_e();
    t_sync();
    report_and_stop();
  end

  // Watchdog well beyond the under two hundred cycles the scenarios need.
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_fail++;
    report_and_stop();
  end
endmodule
